// ===== logic/banked_io_bus_cycle_sequencer.sv
// instruction-cycle sequencer with banked, multiplexed active-low I/O bus control
`timescale 1ns/1ps
`include "cycle_seq_params.svh"

module banked_io_bus_cycle_sequencer (
   input  wire logic                      clock,
   input  wire logic                      reset,
   input  wire logic                      link_clock,
   input  wire logic                      halt_n,
   output logic      [`PC_WIDTH-1:0]      program_address,
   input  wire logic [`INSTR_WIDTH-1:0]   instruction_in,
   output logic                           left_bank_select_n,
   output logic                           right_bank_select_n,
   output logic                           select_command,
   output logic                           write_command,
   input  wire logic [`IV_WIDTH-1:0]      interface_vector_bus_in,
   output logic      [`IV_WIDTH-1:0]      interface_vector_bus_out,
   output logic                           interface_vector_bus_oe,
   output logic                           master_clock
);

   // core state on the system clock
   typedef struct packed {
      cycle_seq_pkg::quarter_t      quarter;
      logic [`QCOUNT_WIDTH-1:0]     qcount;
      logic                         halt_s1;
      logic                         halt_s2;
      logic [`INSTR_WIDTH-1:0]      instr_s1;
      logic [`INSTR_WIDTH-1:0]      instr_s2;
      logic [`INSTR_WIDTH-1:0]      ir;
      logic [`PC_WIDTH-1:0]         pc;
      logic                         left_n;
      logic                         right_n;
      logic                         select;
      logic                         write;
      logic                         mclk;
      logic                         oe;
      logic [`IV_WIDTH-1:0]         iv_out;
      logic [`IV_WIDTH-1:0]         iv_latch;
      logic [`IV_WIDTH-1:0]         aux;
      cycle_seq_pkg::bank_t         bank;
      logic                         halted;
      logic                         waiting;
      logic                         req;
      logic                         ack_s1;
      logic                         ack_s2;
      logic                         we;
      logic [`REG_ADDR_WIDTH-1:0]   wa;
      logic [`IV_WIDTH-1:0]         wd;
   } core_state_t;

   // bus-sampling state on the link clock
   typedef struct packed {
      logic                         rst_s1;
      logic                         rst_s2;
      logic                         req_s1;
      logic                         req_s2;
      logic                         req_s3;
      logic [`IV_WIDTH-1:0]         iv_s1;
      logic [`IV_WIDTH-1:0]         iv_s2;
      logic [`IV_WIDTH-1:0]         word;
      logic                         ack;
   } link_state_t;

   core_state_t               core_reg;
   core_state_t               core_next;
   link_state_t               link_reg;
   link_state_t               link_next;
   logic [`IV_WIDTH-1:0]      rf_read_data;

   // rotate an operand right by 0..7 places
   function automatic logic [`IV_WIDTH-1:0] rotate_right(input logic [`IV_WIDTH-1:0] v,
                                                         input logic [2:0]           n);
      logic [2*`IV_WIDTH-1:0] w;
      w = {v, v} >> n;
      return w[`IV_WIDTH-1:0];
   endfunction

   // length field: 1..7 low bits, zero means all eight
   function automatic logic [`IV_WIDTH-1:0] length_mask(input logic [2:0] len);
      logic [2:0] sh;
      sh = 3'(3'h0 - len);
      return 8'hFF >> sh;
   endfunction

   working_register_file u_regs (
      .clock         (clock),
      .read_address  (core_reg.ir[`SRC_LSB+`REG_ADDR_WIDTH-1:`SRC_LSB]),
      .read_data     (rf_read_data),
      .write_enable  (core_reg.we),
      .write_address (core_reg.wa),
      .write_data    (core_reg.wd)
   );

   // decode and datapath terms
   logic [2:0]                op_q1;
   logic                      src_bus_q1;
   logic                      dst_bus_q1;

   // fields of the word held in the instruction register
   logic [2:0]                op;
   logic [4:0]                src_f;
   logic [2:0]                rl_f;
   logic [4:0]                dst_f;
   logic [4:0]                dest;

   // one pass through rotate, mask, alu, shift and merge
   logic [`IV_WIDTH-1:0]      raw;
   logic [`IV_WIDTH-1:0]      operand;
   logic [`IV_WIDTH:0]        sum9;
   logic [`IV_WIDTH-1:0]      alu;
   logic [`IV_WIDTH-1:0]      value;
   logic [`IV_WIDTH-1:0]      merge_mask;
   logic [`IV_WIDTH-1:0]      merged;

   // sequencing terms
   logic [`PC_WIDTH-1:0]      pc_inc;
   logic                      last;
   logic                      stall;

   always_comb begin
      // predecode of the incoming word, needed before it reaches the instruction register
      op_q1      = core_reg.instr_s2[`OP_MSB:`OP_LSB];
      src_bus_q1 = ~op_q1[2] & core_reg.instr_s2[`SRC_MSB];
      dst_bus_q1 = (~op_q1[2] & core_reg.instr_s2[`DST_MSB])
                 | ((op_q1 == `OP_LITERAL) & core_reg.instr_s2[`SRC_MSB]);
      op    = core_reg.ir[`OP_MSB:`OP_LSB];
      src_f = core_reg.ir[`SRC_MSB:`SRC_LSB];
      rl_f  = core_reg.ir[`RL_MSB:`RL_LSB];
      dst_f = core_reg.ir[`DST_MSB:`DST_LSB];
      // bus data is inverted on the pins, so invert once here
      raw = src_f[4] ? ~link_reg.word : rf_read_data;
      // rotate and mask ahead of the alu
      if (src_f[4]) begin
         operand = rotate_right(raw, src_f[2:0]) & length_mask(rl_f);
      end else if (dst_f[4]) begin
         operand = raw;
      end else begin
         operand = rotate_right(raw, rl_f);
      end
      sum9 = {1'b0, operand} + {1'b0, core_reg.aux};
      unique case (op)
         `OP_ADD: alu = sum9[`IV_WIDTH-1:0];
         `OP_AND: alu = operand & core_reg.aux;
         `OP_XOR: alu = operand ^ core_reg.aux;
         default: alu = operand;
      endcase
      dest  = (op == `OP_LITERAL) ? src_f : dst_f;
      value = (op == `OP_LITERAL) ? core_reg.ir[`IV_WIDTH-1:0] : alu;
      // shift and merge after the alu, into the held output latch
      merge_mask = length_mask(rl_f) << dest[2:0];
      merged     = (core_reg.iv_latch & ~merge_mask) | ((value << dest[2:0]) & merge_mask);
      pc_inc     = core_reg.pc + 13'h0001;
      last       = (core_reg.qcount == 2'(`QUARTER_CYCLES - 1));
      // the read word is trusted only once its acknowledge has crossed over
      stall      = (core_reg.quarter == cycle_seq_pkg::quarter_two) && core_reg.waiting
                && (core_reg.ack_s2 != core_reg.req);
   end

   // core sequencer: one instruction per four quarters
   always_comb begin
      core_next          = core_reg;
      // pins pass two flops each; only the second flop is read
      core_next.halt_s1  = halt_n;
      core_next.halt_s2  = core_reg.halt_s1;
      core_next.instr_s1 = instruction_in;
      core_next.instr_s2 = core_reg.instr_s1;
      // acknowledge toggle coming back from the link clock
      core_next.ack_s1   = link_reg.ack;
      core_next.ack_s2   = core_reg.ack_s1;
      core_next.we       = 1'b0;
      // quarter count; a bus read stretches quarter two until the word arrives
      if (!last) begin
         core_next.qcount = core_reg.qcount + 2'h1;
      end else if (!stall) begin
         core_next.qcount = '0;
      end
      // master clock is one clock wide, so it falls well before strobes change
      if (core_reg.quarter == cycle_seq_pkg::quarter_four && core_reg.mclk) begin
         core_next.mclk = 1'b0;
      end
      if (last && !stall) begin
         unique case (core_reg.quarter)
            cycle_seq_pkg::quarter_one: begin
               core_next.quarter = cycle_seq_pkg::quarter_two;
               // a halted cycle keeps ir, pc and the registers untouched
               if (!core_reg.halted) begin
                  core_next.ir = core_reg.instr_s2;
                  // bank from the last device address; bank_t keeps them exclusive
                  if (src_bus_q1 || dst_bus_q1) begin
                     core_next.left_n  = (core_reg.bank != cycle_seq_pkg::bank_left);
                     core_next.right_n = (core_reg.bank != cycle_seq_pkg::bank_right);
                  end
                  // sampling only with a bank enabled and both strobes low
                  if (src_bus_q1 && core_reg.bank != cycle_seq_pkg::bank_none) begin
                     core_next.req     = ~core_reg.req;
                     core_next.waiting = 1'b1;
                  end
               end
            end
            cycle_seq_pkg::quarter_two: begin
               // input latches close here: the sampled word is consumed now
               core_next.quarter = cycle_seq_pkg::quarter_three;
               core_next.waiting = 1'b0;
               if (!core_reg.halted) begin
                  unique case (op)
                     `OP_EXEC: begin
                        core_next.pc = {core_reg.pc[`PC_WIDTH-1:`IV_WIDTH],
                                        core_reg.ir[`IV_WIDTH-1:0] + raw};
                     end
                     `OP_NZ_JUMP: begin
                        core_next.pc = (raw != '0) ? {core_reg.pc[`PC_WIDTH-1:`IV_WIDTH],
                                                      core_reg.ir[`IV_WIDTH-1:0]} : pc_inc;
                     end
                     `OP_JUMP: core_next.pc = core_reg.ir[`PC_WIDTH-1:0];
                     default:  core_next.pc = pc_inc;
                  endcase
                  if (!op[2] || op == `OP_LITERAL) begin
                     if (dest[4]) begin
                        // data output, only onto a bank that is enabled
                        core_next.iv_latch = (op == `OP_LITERAL) ? value : merged;
                        if (core_reg.bank != cycle_seq_pkg::bank_none) begin
                           core_next.iv_out = ~((op == `OP_LITERAL) ? value : merged);
                           core_next.write  = 1'b1;
                           core_next.oe     = 1'b1;
                        end
                     end else begin
                        core_next.we = 1'b1;
                        core_next.wa = dest[`REG_ADDR_WIDTH-1:0];
                        core_next.wd = value;
                        if (dest[`REG_ADDR_WIDTH-1:0] == `REG_AUX) begin
                           core_next.aux = value;
                        end
                        // device address output selects the new bank for this cycle
                        if (dest == `DST_LEFT_VECTOR || dest == `DST_RIGHT_VECTOR) begin
                           core_next.bank    = (dest == `DST_LEFT_VECTOR) ?
                                               cycle_seq_pkg::bank_left : cycle_seq_pkg::bank_right;
                           core_next.left_n  = (dest != `DST_LEFT_VECTOR);
                           core_next.right_n = (dest == `DST_LEFT_VECTOR);
                           core_next.iv_out  = ~value;
                           core_next.select  = 1'b1;
                           core_next.oe      = 1'b1;
                        end
                     end
                  end
               end
            end
            cycle_seq_pkg::quarter_three: begin
               // address and strobes already stand, so the pulse opens quarter four
               core_next.quarter = cycle_seq_pkg::quarter_four;
               core_next.mclk    = 1'b1;
            end
            cycle_seq_pkg::quarter_four: begin
               // strobes and banks drop only after the master clock pulse has ended
               core_next.quarter = cycle_seq_pkg::quarter_one;
               core_next.mclk    = 1'b0;
               core_next.select  = 1'b0;
               core_next.write   = 1'b0;
               core_next.oe      = 1'b0;
               core_next.left_n  = 1'b1;
               core_next.right_n = 1'b1;
               core_next.halted  = ~core_reg.halt_s2;
            end
         endcase
      end
   end

   // reset idles the first cycle so the instruction synchroniser can fill
   always_ff @(posedge clock) begin
      if (reset) begin
         // bank selects idle high and the first cycle fetches nothing
         core_reg         <= '0;
         core_reg.left_n  <= 1'b1;
         core_reg.right_n <= 1'b1;
         core_reg.halted  <= 1'b1;
      end else begin
         core_reg <= core_next;
      end
   end

   // link side: samples the bus pins on request and hands the word back by toggle
   always_comb begin
      link_next        = link_reg;
      link_next.rst_s1 = reset;
      link_next.rst_s2 = link_reg.rst_s1;
      link_next.req_s1 = core_reg.req;
      link_next.req_s2 = link_reg.req_s1;
      link_next.req_s3 = link_reg.req_s2;
      // bus pins likewise cross on two flops before the word takes them
      link_next.iv_s1  = interface_vector_bus_in;
      link_next.iv_s2  = link_reg.iv_s1;
      if (link_reg.rst_s2) begin
         // core reset, seen here after its own two flops
         link_next.req_s1 = 1'b0;
         link_next.req_s2 = 1'b0;
         link_next.req_s3 = 1'b0;
         link_next.word   = '0;
         link_next.ack    = 1'b0;
      end else if (link_reg.req_s2 != link_reg.req_s3) begin
         // word is held until the next request, so the core reads it steady
         link_next.word = link_reg.iv_s2;
         link_next.ack  = link_reg.req_s2;
      end
   end

   always_ff @(posedge link_clock) begin
      link_reg <= link_next;
   end

   // outputs straight from core flip-flops
   assign program_address          = core_reg.pc;
   assign left_bank_select_n       = core_reg.left_n;
   assign right_bank_select_n      = core_reg.right_n;
   assign select_command           = core_reg.select;
   assign write_command            = core_reg.write;
   assign interface_vector_bus_out = core_reg.iv_out;
   assign interface_vector_bus_oe  = core_reg.oe;
   assign master_clock             = core_reg.mclk;

endmodule // banked_io_bus_cycle_sequencer

// ===== logic/cycle_seq_params.svh
// constants of the instruction-cycle sequencer: widths, field positions, opcodes, timing
`ifndef CYCLE_SEQ_PARAMS_SVH
`define CYCLE_SEQ_PARAMS_SVH

// timing: one quarter lasts at least the printed time, rounded up to whole clocks
`define CLOCK_PERIOD_NS   25
`define QUARTER_MIN_NS    50
`define QUARTER_CYCLES    ((`QUARTER_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define QCOUNT_WIDTH      2

// bus and word widths
`define PC_WIDTH          13
`define INSTR_WIDTH       16
`define IV_WIDTH          8
`define REG_COUNT         16
`define REG_ADDR_WIDTH    4

// instruction fields, opcode in the top bits
`define OP_MSB            15
`define OP_LSB            13
`define SRC_MSB           12
`define SRC_LSB           8
`define RL_MSB            7
`define RL_LSB            5
`define DST_MSB           4
`define DST_LSB           0

// opcode classes
`define OP_MOVE           3'h0
`define OP_ADD            3'h1
`define OP_AND            3'h2
`define OP_XOR            3'h3
`define OP_EXEC           3'h4
`define OP_NZ_JUMP        3'h5
`define OP_LITERAL        3'h6
`define OP_JUMP           3'h7

// destinations that also put a device address on the bus, and the aux register address
`define DST_LEFT_VECTOR   5'h07
`define DST_RIGHT_VECTOR  5'h0F
`define REG_AUX           4'h0

`endif

// ===== logic/cycle_seq_pkg.sv
// types used by the instruction-cycle sequencer alone, not by its register file
package cycle_seq_pkg;

   // four quarters of one instruction cycle
   typedef enum logic [1:0] {
      quarter_one,
      quarter_two,
      quarter_three,
      quarter_four
   } quarter_t;

   // bank remembered from the last device-address output
   typedef enum logic [1:0] {
      bank_none,
      bank_left,
      bank_right
   } bank_t;

endpackage

// ===== logic/working_register_file.sv
// sixteen 8-bit working registers, one registered read port and one write port
`timescale 1ns/1ps
`include "cycle_seq_params.svh"

module working_register_file (
   input  wire logic                         clock,
   input  wire logic [`REG_ADDR_WIDTH-1:0]   read_address,
   output logic      [`IV_WIDTH-1:0]         read_data,
   input  wire logic                         write_enable,
   input  wire logic [`REG_ADDR_WIDTH-1:0]   write_address,
   input  wire logic [`IV_WIDTH-1:0]         write_data
);

   typedef struct packed {
      logic [`REG_COUNT-1:0][`IV_WIDTH-1:0] words;
      logic [`IV_WIDTH-1:0]                 data;
   } file_state_t;

   file_state_t file_reg;
   file_state_t file_next;

   // no reset: contents survive halt and reset, as working storage should
   always_comb begin
      file_next      = file_reg;
      file_next.data = file_reg.words[read_address];
      if (write_enable) begin
         file_next.words[write_address] = write_data;
      end
   end

   always_ff @(posedge clock) begin
      file_reg <= file_next;
   end

   assign read_data = file_reg.data;

endmodule // working_register_file

// ===== verification/cycle_seq_chk.sv
// assertions on the sequencer's bank selects, strobes and cycle timing
`timescale 1ns/1ps
`include "cycle_seq_params.svh"

module cycle_seq_chk (
   input wire logic                 clock,
   input wire logic                 reset,
   input wire logic [`PC_WIDTH-1:0] program_address,
   input wire logic                 left_bank_select_n,
   input wire logic                 right_bank_select_n,
   input wire logic                 select_command,
   input wire logic                 write_command,
   input wire logic [`IV_WIDTH-1:0] interface_vector_bus_out,
   input wire logic                 interface_vector_bus_oe,
   input wire logic                 master_clock
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // everything a peripheral latches on the master clock
   wire logic [12:0] held = {left_bank_select_n, right_bank_select_n, select_command,
      write_command, interface_vector_bus_oe, interface_vector_bus_out};
   // next address and strobes lead the pulse by exactly one quarter
   sequence quarter_then_pulse;
      ##2 $rose(master_clock);
   endsequence
   sequence held_across_pulse;
      $stable(held) ##1 $stable(held);
   endsequence

   AST_BANKS_EXCLUSIVE: assert property (left_bank_select_n || right_bank_select_n)
      else $error("both bank selects low");
   AST_STROBES_EXCLUSIVE: assert property (!(select_command && write_command))
      else $error("select and write strobes high together");
   AST_NO_BANK_NO_BUS: assert property (left_bank_select_n && right_bank_select_n |->
      !interface_vector_bus_oe && !select_command && !write_command)
      else $error("bus active with no bank");
   AST_DRIVE_WITH_STROBE: assert property (
      interface_vector_bus_oe == (select_command || write_command))
      else $error("bus drive without a strobe");
   AST_PULSE_SPACING: assert property ($rose(master_clock) |=> !master_clock [*7])
      else $error("master clock pulse too long or cycle too short");
   AST_HELD_AT_PULSE: assert property ($rose(master_clock) |-> held_across_pulse)
      else $error("bus moved around the master clock");
   AST_ADDRESS_LEADS: assert property ($changed(program_address) |-> quarter_then_pulse)
      else $error("program address not a quarter before the pulse");
   AST_STROBE_LEADS: assert property (
      $rose(select_command || write_command) |-> quarter_then_pulse)
      else $error("strobe not a quarter before the pulse");
   AST_RESET_STATE: assert property (disable iff (1'b0) reset [*2] |->
      program_address == 0 && left_bank_select_n && right_bank_select_n && !master_clock)
      else $error("reset state wrong");
endmodule // cycle_seq_chk

bind banked_io_bus_cycle_sequencer cycle_seq_chk i_chk (
   .clock(clock), .reset(reset), .program_address(program_address),
   .left_bank_select_n(left_bank_select_n), .right_bank_select_n(right_bank_select_n),
   .select_command(select_command), .write_command(write_command),
   .interface_vector_bus_out(interface_vector_bus_out),
   .interface_vector_bus_oe(interface_vector_bus_oe), .master_clock(master_clock));

// ===== verification/io_partner_model.sv
// program storage and two banks of bus peripherals facing the sequencer
`timescale 1ns/1ps
`include "cycle_seq_params.svh"

module io_partner_model #(
   parameter int ACCESS_NS = 60
) (
   input  wire logic                    clock,
   input  wire logic [`PC_WIDTH-1:0]    prog_addr,
   output logic      [`INSTR_WIDTH-1:0] instr,
   input  wire logic                    left_n,
   input  wire logic                    right_n,
   input  wire logic                    sel_cmd,
   input  wire logic                    wr_cmd,
   input  wire logic                    mclk,
   input  wire logic [`IV_WIDTH-1:0]    bus_out,
   output logic      [`IV_WIDTH-1:0]    drive
);
   logic [15:0] prog [0:8191];
   logic [7:0]  mem [0:1][0:255];
   logic [7:0]  location [0:1];
   logic        idle_toggle = 1'b0;
   wire logic   side = !right_n;
   // storage answers after its access time, well clear of the fetch edge
   assign #(ACCESS_NS) instr = prog[prog_addr];
   // capture as the master clock falls, while the device still holds the bus
   always @(negedge mclk) begin
      if (sel_cmd) begin
         location[side] <= ~bus_out;
      end else if (wr_cmd) begin
         mem[side][location[side]] <= ~bus_out;
      end
   end
   always @(posedge clock) idle_toggle <= ~idle_toggle;
   // a released wire changes every cycle, so a stale value is never read
   assign drive = (!(left_n && right_n) && !sel_cmd && !wr_cmd) ?
      ~mem[side][location[side]] : {8{idle_toggle}};
endmodule // io_partner_model

// ===== verification/testbench.sv
// self-checking bench: program table, bank traffic, halt through a second reset
`timescale 1ns/1ps
`include "cycle_seq_params.svh"

module testbench;
   typedef struct packed {
      logic [15:0] instr;
      logic [12:0] pc;
      logic [4:0]  ctl;
      logic [7:0]  bus;
   } row_t;
   logic        clock = 1'b0;
   logic        link_clock = 1'b0;
   logic        reset = 1'b1;
   logic        halt_n = 1'b1;
   logic [12:0] prog_addr;
   logic [15:0] instr;
   logic        left_n, right_n, sel_cmd, wr_cmd, bus_oe, master_clock;
   logic [7:0]  bus_out, bus_in, drive;
   int          num_errors = 0;
   int          total_checks = 0;
   int          n;
   // ctl is left, right, select, write, drive; row 5 reads, row 6 writes back,
   // rows 8 to 10 take the alu onto the bus, row 11 branches through a register
   row_t rows [0:12] = '{
      '{16'hC7A5, 13'h0001, 5'h0D, 8'h5A}, '{16'hD03C, 13'h0002, 5'h0B, 8'hC3},
      '{16'hCF5A, 13'h0003, 5'h15, 8'hA5}, '{16'hD0C3, 13'h0004, 5'h13, 8'h3C},
      '{16'hC7A5, 13'h0005, 5'h0D, 8'h5A}, '{16'h1001, 13'h0006, 5'h08, 8'h00},
      '{16'h0110, 13'h0007, 5'h0B, 8'hC3}, '{16'hC011, 13'h0008, 5'h18, 8'h00},
      '{16'h2110, 13'h0009, 5'h0B, 8'hB2}, '{16'h6194, 13'h000A, 5'h0B, 8'h22},
      '{16'h4110, 13'h000B, 5'h0B, 8'hEF}, '{16'h81D0, 13'h000C, 5'h18, 8'h00},
      '{16'hE00C, 13'h000C, 5'h18, 8'h00}};

   initial forever #12.5 clock = ~clock;
   initial begin
      #37;
      forever #80 link_clock = ~link_clock;
   end
   // device drive wins, otherwise the peripheral side sets the wire
   assign bus_in = bus_oe ? bus_out : drive;

   banked_io_bus_cycle_sequencer i_dut (
      .clock(clock), .reset(reset), .link_clock(link_clock), .halt_n(halt_n),
      .program_address(prog_addr), .instruction_in(instr),
      .left_bank_select_n(left_n), .right_bank_select_n(right_n),
      .select_command(sel_cmd), .write_command(wr_cmd),
      .interface_vector_bus_in(bus_in), .interface_vector_bus_out(bus_out),
      .interface_vector_bus_oe(bus_oe), .master_clock(master_clock));
   io_partner_model i_partner (
      .clock(clock), .prog_addr(prog_addr), .instr(instr), .left_n(left_n),
      .right_n(right_n), .sel_cmd(sel_cmd), .wr_cmd(wr_cmd), .bus_out(bus_out),
      .mclk(master_clock), .drive(drive));

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // next master clock pulse, sampled at the falling edge inside it
   task automatic wait_pulse;
      int k;
      k = 0;
      @(negedge clock);
      while (master_clock !== 1'b1 && k < 200) begin
         @(negedge clock);
         k++;
      end
      if (k == 200) begin
         num_errors++;
         $display("MISMATCH %0t no master clock pulse", $time);
         test_done();
      end
   endtask
   task automatic apply_reset(input logic halt_level);
      reset = 1'b1;
      halt_n = halt_level;
      repeat (12) @(negedge clock);
      check_vec({1'b0, left_n, right_n, prog_addr}, 16'h6000, "reset state");
      reset = 1'b0;
   endtask

   initial begin
      foreach (rows[i]) i_partner.prog[i] = rows[i].instr;
      apply_reset(1'b1);
      wait_pulse;
      foreach (rows[i]) begin
         wait_pulse;
         check_vec({3'h0, prog_addr}, {3'h0, rows[i].pc}, "next address");
         check_vec({11'h0, left_n, right_n, sel_cmd, wr_cmd, bus_oe}, {11'h0, rows[i].ctl},
            "bus control");
         if (rows[i].ctl[0])
            check_vec({8'h0, bus_out}, {8'h0, rows[i].bus}, "bus value");
      end
      check_vec({8'h0, i_partner.mem[0][8'hA5]}, 16'h0010, "left location");
      check_vec({8'h0, i_partner.mem[1][8'h5A]}, 16'h00C3, "right location");
      $display("test program table done");
      // halt held through a second reset: cycles idle, pulses keep coming
      apply_reset(1'b0);
      repeat (3) begin
         wait_pulse;
         check_vec({1'b0, left_n, right_n, prog_addr}, 16'h6000, "halted cycle");
      end
      halt_n = 1'b1;
      n = 0;
      while (sel_cmd !== 1'b1 && n < 3) begin
         wait_pulse;
         n++;
      end
      check_vec({8'h0, bus_out}, 16'h005A, "first output after halt");
      $display("test halt and second reset done");
      test_done();
   end
endmodule // testbench
